// *** design/rsi_bus_if.sv ***
// Parallel register bus between the host and the signaling buffer port.
`timescale 1ns/1ps
`default_nettype none
interface rsi_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic irq;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface
`default_nettype wire

// *** design/rsi_device.sv ***
// Device end: register port of the receive signaling buffer with indirect channel access.
`timescale 1ns/1ps
`default_nettype none
`include "rsi_map.svh"
// Function
// - Busy reads 1 during indirect transfer.
// - Busy reads 0 when nothing pending.
// - Host waits for busy low before access.
// - Control bit 7: 0 writes, 1 reads.
// - Low seven bits address channels 01H-18H.
// - Host loads data before write command.
// - Read command loads data register with byte.
// - Signaling change on channel sets its flag; here only with extract on and freeze off.
// - Write one clears flag; reset zero.
// - Flags packed eight per register, D6H-D8H.
// - Indirect registers hold signaling and extract-enable.
// - Enabled flags drive the interrupt output.
module rsi_device #(
  parameter int CHANNELS = 24,
  parameter int XFER_CYCLES = `RSI_XFER_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  rsi_bus_if.dev bus,
  input wire logic sig_upd,
  input wire logic [4:0] sig_chan,
  input wire logic [3:0] sig_abcd,
  output logic [23:0] sig_change,
  output logic busy
);
  if (CHANNELS < 1 || CHANNELS > 24 || XFER_CYCLES < 1 || XFER_CYCLES > 15) begin : g_chk
    $error("rsi_device: CHANNELS must be 1..24 and XFER_CYCLES 1..15");
  end

  localparam logic [6:0] LAST_ADDR = 7'(int'(`RSI_IND_FIRST) + CHANNELS - 1);
  localparam logic [3:0] XFER_LOAD = 4'(XFER_CYCLES - 1);

  // Transfer sequencer.
  rsi_pkg::rsi_dev_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic start;
  logic done;

  // Bus-visible registers.
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] data_r, data_nxt;
  logic [23:0] flag_r, flag_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;

  // Per-channel indirect registers.
  logic [CHANNELS-1:0] ext_r, ext_nxt;
  logic [3:0] abcd_r [CHANNELS];
  logic [3:0] abcd_nxt [CHANNELS];

  logic [23:0] set_v;
  logic [23:0] clr_v;
  logic ind_ok;
  logic [4:0] ind_idx;
  logic [7:0] ind_val;
  logic upd_ok;
  logic [4:0] upd_idx;

  assign busy = (state_r == rsi_pkg::RSI_DEV_XFER);
  assign done = busy && (cnt_r == 4'h0);
  assign bus.rdata = rdata_r;
  assign bus.irq = irq_r;
  assign sig_change = flag_r;

  // Indirect address decode; out-of-range targets read as zero and ignore writes.
  assign ind_ok = (ctrl_r[6:0] >= `RSI_IND_FIRST) && (ctrl_r[6:0] <= LAST_ADDR);
  assign ind_idx = 5'(ctrl_r[6:0] - `RSI_IND_FIRST);
  assign upd_ok = sig_upd && ({2'h0, sig_chan} >= `RSI_IND_FIRST) && ({2'h0, sig_chan} <= LAST_ADDR);
  assign upd_idx = 5'(sig_chan - 5'h01);

  always_comb begin
    ind_val = 8'h00;
    if (ind_ok) begin
      ind_val = {3'h0, ext_r[ind_idx], abcd_r[ind_idx]};
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      rsi_pkg::RSI_DEV_IDLE: begin
        if (start) begin
          state_nxt = rsi_pkg::RSI_DEV_XFER;
          cnt_nxt = XFER_LOAD;
        end
      end
      rsi_pkg::RSI_DEV_XFER: begin
        if (cnt_r == 4'h0) begin
          state_nxt = rsi_pkg::RSI_DEV_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = rsi_pkg::RSI_DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= rsi_pkg::RSI_DEV_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Channel store: extract enable is software-written, signaling bits follow the line while extract is on and updates are not frozen.
  always_comb begin
    ext_nxt = ext_r;
    abcd_nxt = abcd_r;
    set_v = 24'h000000;
    if (done && !ctrl_r[`RSI_CTRL_READ_NOT_WRITE_FLAG] && ind_ok) begin
      ext_nxt[ind_idx] = data_r[`RSI_EXT_BIT];
    end
    if (upd_ok && ext_r[upd_idx] && !cfg_r[`RSI_CFG_FREEZE]) begin
      abcd_nxt[upd_idx] = sig_abcd;
      if (sig_abcd != abcd_r[upd_idx]) begin
        set_v[upd_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_r <= {CHANNELS{`RSI_EXT_RST}};
      for (int i = 0; i < CHANNELS; i++) begin
        abcd_r[i] <= `RSI_ABCD_RST;
      end
    end else begin
      ext_r <= ext_nxt;
      abcd_r <= abcd_nxt;
    end
  end

  // Register bus: write decode, read decode, flags and interrupt.
  always_comb begin
    cfg_nxt = cfg_r;
    ctrl_nxt = ctrl_r;
    data_nxt = data_r;
    rdata_nxt = rdata_r;
    clr_v = 24'h000000;
    start = 1'b0;
    if (bus.wr) begin
      if (bus.addr == `RSI_OFF_CFG) begin
        cfg_nxt = bus.wdata;
      end else if (bus.addr == `RSI_OFF_CTRL) begin
        // A command while busy is dropped so the running transfer keeps its operands.
        if (!busy) begin
          ctrl_nxt = bus.wdata;
          start = 1'b1;
        end
      end else if (bus.addr == `RSI_OFF_DATA) begin
        if (!busy) begin
          data_nxt = bus.wdata;
        end
      end else if (bus.addr == `RSI_OFF_FLAG0) begin
        clr_v[7:0] = bus.wdata;
      end else if (bus.addr == `RSI_OFF_FLAG1) begin
        clr_v[15:8] = bus.wdata;
      end else if (bus.addr == `RSI_OFF_FLAG2) begin
        clr_v[23:16] = bus.wdata;
      end
    end
    if (done && ctrl_r[`RSI_CTRL_READ_NOT_WRITE_FLAG]) begin
      data_nxt = ind_val;
    end
    // A new change in the same cycle as its clear keeps the flag set.
    flag_nxt = (flag_r & ~clr_v) | set_v;
    irq_nxt = cfg_nxt[`RSI_CFG_SIGNALING_CHANGE_IRQ_ENABLE] && (|flag_nxt);
    if (bus.rd) begin
      if (bus.addr == `RSI_OFF_CFG) begin
        rdata_nxt = cfg_r;
      end else if (bus.addr == `RSI_OFF_STATUS) begin
        rdata_nxt = {7'h00, busy};
      end else if (bus.addr == `RSI_OFF_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (bus.addr == `RSI_OFF_DATA) begin
        rdata_nxt = data_r;
      end else if (bus.addr == `RSI_OFF_FLAG0) begin
        rdata_nxt = flag_r[7:0];
      end else if (bus.addr == `RSI_OFF_FLAG1) begin
        rdata_nxt = flag_r[15:8];
      end else if (bus.addr == `RSI_OFF_FLAG2) begin
        rdata_nxt = flag_r[23:16];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= `RSI_CFG_RST;
      ctrl_r <= `RSI_CTRL_RST;
      data_r <= `RSI_DATA_RST;
      flag_r <= 24'h000000;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
      data_r <= data_nxt;
      flag_r <= flag_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end
endmodule
`default_nettype wire

// *** design/rsi_host.sv ***
// Host end: runs direct and indirect register accesses on the signaling buffer port.
`timescale 1ns/1ps
`default_nettype none
`include "rsi_map.svh"
module rsi_host (
  input wire logic clk,
  input wire logic sys_rst,
  rsi_bus_if.host bus,
  input wire logic req,
  input wire rsi_pkg::rsi_req_e req_kind,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  output logic ready,
  output logic done,
  output logic err,
  output logic [7:0] rsp_data,
  output logic irq
);
  rsi_pkg::rsi_host_state_e state_r, state_nxt;
  rsi_pkg::rsi_req_e kind_r, kind_nxt;
  logic [6:0] iaddr_r, iaddr_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic [7:0] rsp_r, rsp_nxt;
  logic err_r, err_nxt;
  logic ind_kind;
  logic ind_ok;

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign ready = (state_r == rsi_pkg::RSI_H_IDLE);
  assign done = (state_r == rsi_pkg::RSI_H_FIN);
  assign err = err_r;
  assign rsp_data = rsp_r;
  assign irq = bus.irq;
  assign ind_kind = (req_kind == rsi_pkg::RSI_REQ_IND_WR) || (req_kind == rsi_pkg::RSI_REQ_IND_RD);
  assign ind_ok = (req_addr[7] == 1'b0) && (req_addr[6:0] >= `RSI_IND_FIRST)
                  && (req_addr[6:0] <= `RSI_IND_LAST);

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    iaddr_nxt = iaddr_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    rsp_nxt = rsp_r;
    err_nxt = err_r;
    case (state_r)
      rsi_pkg::RSI_H_IDLE: begin
        if (req) begin
          kind_nxt = req_kind;
          iaddr_nxt = req_addr[6:0];
          err_nxt = 1'b0;
          if (ind_kind && !ind_ok) begin
            err_nxt = 1'b1;
            state_nxt = rsi_pkg::RSI_H_FIN;
          end else if (req_kind == rsi_pkg::RSI_REQ_IND_WR) begin
            addr_nxt = `RSI_OFF_DATA;
            wdata_nxt = req_data;
            wr_nxt = 1'b1;
            state_nxt = rsi_pkg::RSI_H_WR_CTRL;
          end else if (req_kind == rsi_pkg::RSI_REQ_IND_RD) begin
            addr_nxt = `RSI_OFF_CTRL;
            wdata_nxt = {1'b1, req_addr[6:0]};
            wr_nxt = 1'b1;
            state_nxt = rsi_pkg::RSI_H_POLL;
          end else if (req_kind == rsi_pkg::RSI_REQ_DIR_WR) begin
            addr_nxt = req_addr;
            wdata_nxt = req_data;
            wr_nxt = 1'b1;
            state_nxt = rsi_pkg::RSI_H_FIN;
          end else begin
            addr_nxt = req_addr;
            rd_nxt = 1'b1;
            state_nxt = rsi_pkg::RSI_H_RD_CAP;
          end
        end
      end
      rsi_pkg::RSI_H_WR_CTRL: begin
        addr_nxt = `RSI_OFF_CTRL;
        wdata_nxt = {1'b0, iaddr_r};
        wr_nxt = 1'b1;
        state_nxt = rsi_pkg::RSI_H_POLL;
      end
      rsi_pkg::RSI_H_POLL: begin
        addr_nxt = `RSI_OFF_STATUS;
        rd_nxt = 1'b1;
        state_nxt = rsi_pkg::RSI_H_POLL_CAP;
      end
      rsi_pkg::RSI_H_POLL_CAP: begin
        state_nxt = rsi_pkg::RSI_H_POLL_CHK;
      end
      rsi_pkg::RSI_H_POLL_CHK: begin
        if (bus.rdata[`RSI_STATUS_BUSY]) begin
          addr_nxt = `RSI_OFF_STATUS;
          rd_nxt = 1'b1;
          state_nxt = rsi_pkg::RSI_H_POLL_CAP;
        end else if (kind_r == rsi_pkg::RSI_REQ_IND_RD) begin
          addr_nxt = `RSI_OFF_DATA;
          rd_nxt = 1'b1;
          state_nxt = rsi_pkg::RSI_H_RD_CAP;
        end else begin
          state_nxt = rsi_pkg::RSI_H_FIN;
        end
      end
      rsi_pkg::RSI_H_RD_CAP: begin
        state_nxt = rsi_pkg::RSI_H_RD_CHK;
      end
      rsi_pkg::RSI_H_RD_CHK: begin
        rsp_nxt = bus.rdata;
        state_nxt = rsi_pkg::RSI_H_FIN;
      end
      rsi_pkg::RSI_H_FIN: begin
        state_nxt = rsi_pkg::RSI_H_IDLE;
      end
      default: begin
        state_nxt = rsi_pkg::RSI_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= rsi_pkg::RSI_H_IDLE;
      kind_r <= rsi_pkg::RSI_REQ_IND_WR;
      iaddr_r <= 7'h00;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rsp_r <= 8'h00;
      err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      iaddr_r <= iaddr_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      rsp_r <= rsp_nxt;
      err_r <= err_nxt;
    end
  end
endmodule
`default_nettype wire

// *** design/rsi_map.svh ***
// Register offsets, field positions, reset values and timing counts of the signaling buffer port.
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH
`define RSI_OFF_CFG 8'hd2
`define RSI_OFF_STATUS 8'hd3
`define RSI_OFF_CTRL 8'hd4
`define RSI_OFF_DATA 8'hd5
`define RSI_OFF_FLAG0 8'hd6
`define RSI_OFF_FLAG1 8'hd7
`define RSI_OFF_FLAG2 8'hd8
`define RSI_CFG_RST 8'h01
`define RSI_CFG_SIGNALING_CHANGE_IRQ_ENABLE 1
`define RSI_CFG_FREEZE 3
`define RSI_CTRL_READ_NOT_WRITE_FLAG 7
`define RSI_CTRL_RST 8'h00
`define RSI_DATA_RST 8'h00
`define RSI_STATUS_BUSY 0
`define RSI_IND_FIRST 7'h01
`define RSI_IND_LAST 7'h18
`define RSI_EXT_BIT 4
`define RSI_EXT_RST 1'b1
`define RSI_ABCD_RST 4'h0
`define RSI_XFER_CYCLES 3
`endif

// *** design/rsi_pkg.sv ***
// Types shared by both ends of the signaling buffer port.
package rsi_pkg;
  typedef enum logic [1:0] {RSI_REQ_IND_WR, RSI_REQ_IND_RD, RSI_REQ_DIR_WR, RSI_REQ_DIR_RD} rsi_req_e;
  typedef enum {RSI_DEV_IDLE, RSI_DEV_XFER} rsi_dev_state_e;
  typedef enum {
    RSI_H_IDLE, RSI_H_WR_CTRL, RSI_H_POLL, RSI_H_POLL_CAP, RSI_H_POLL_CHK,
    RSI_H_RD_CAP, RSI_H_RD_CHK, RSI_H_FIN
  } rsi_host_state_e;
endpackage

// *** dv/rsi_assertions.sv ***
// Checker on the bus and status lines between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module rsi_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic irq,
  input wire logic busy,
  input wire logic sig_upd,
  input wire logic [23:0] sig_change
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  busy_rise_a:
    assert property (wr && addr == 8'hd4 && !busy |=> busy)
    else $error("busy did not rise");
  busy_len_a:
    assert property ($rose(busy) |-> busy [*3] ##1 !busy)
    else $error("busy length wrong");
  busy_idle_a:
    assert property (!busy && !(wr && addr == 8'hd4) |=> !busy)
    else $error("busy without command");
  host_waits_a:
    assert property (wr && addr == 8'hd4 |-> !busy)
    else $error("command while busy");
  data_first_a:
    assert property (wr && addr == 8'hd4 && !wdata[7] |-> $past(wr) && $past(addr) == 8'hd5)
    else $error("write command without data");
  data_read_a:
    assert property (rd && addr == 8'hd5 |-> !busy)
    else $error("data read while busy");
  flag_clear_a:
    assert property (wr && addr == 8'hd6 && !sig_upd |=> (sig_change[7:0] & $past(wdata)) == 8'h00)
    else $error("flags not cleared");
  flag_rise_a:
    assert property (!sig_upd |=> (sig_change & ~$past(sig_change)) == 24'h000000)
    else $error("flag set without update");
  irq_src_a:
    assert property (irq |-> |sig_change)
    else $error("interrupt without flag");
endmodule
`default_nettype wire

// *** dv/rsi_bench.sv ***
// Self-checking bench joining the host and device ends of the signaling buffer port.
`timescale 1ns/1ps
`default_nettype none
module rsi_bench;
  localparam rsi_pkg::rsi_req_e dwr = rsi_pkg::RSI_REQ_DIR_WR;
  localparam rsi_pkg::rsi_req_e drd = rsi_pkg::RSI_REQ_DIR_RD;
  localparam rsi_pkg::rsi_req_e iwr = rsi_pkg::RSI_REQ_IND_WR;
  localparam rsi_pkg::rsi_req_e ird = rsi_pkg::RSI_REQ_IND_RD;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0;
  rsi_pkg::rsi_req_e req_kind = drd;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic sig_upd = 1'b0;
  logic [4:0] sig_chan = 5'h01;
  logic [3:0] sig_abcd = 4'h0;
  logic ready, done, err, irq, busy;
  logic [7:0] rsp_data, got;
  logic [23:0] sig_change;
  logic [23:0] flags_m = 24'h000000;
  logic [23:0] ext_m = 24'hffffff;
  logic freeze_m = 1'b0;
  logic [3:0] abcd_m [1:24];
  logic [15:0] rst_tab [8] = '{16'hd201, 16'hd300, 16'hd400, 16'hd500, 16'hd600, 16'hd700,
    16'hd800, 16'h1000};
  int num_errors = 0;
  int tests_run = 0;
  rsi_bus_if bus ();
  always #5 clk = ~clk;
  rsi_device u_rsi_device (.clk(clk), .sys_rst(sys_rst), .bus(bus), .sig_upd(sig_upd),
    .sig_chan(sig_chan), .sig_abcd(sig_abcd), .sig_change(sig_change), .busy(busy));
  rsi_host u_rsi_host (.clk(clk), .sys_rst(sys_rst), .bus(bus), .req(req), .req_kind(req_kind),
    .req_addr(req_addr), .req_data(req_data), .ready(ready), .done(done), .err(err),
    .rsp_data(rsp_data), .irq(irq));
  rsi_assertions u_rsi_assertions (.clk(clk), .sys_rst(sys_rst), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .wr(bus.wr), .rd(bus.rd), .irq(bus.irq),
    .busy(busy), .sig_upd(sig_upd), .sig_change(sig_change));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  // Hands one request to the host end and waits for its completion pulse.
  task automatic run(input rsi_pkg::rsi_req_e kind, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 100) begin
      num_errors++;
      report_and_stop();
    end
    req = 1'b1;
    req_kind = kind;
    req_addr = a;
    req_data = d;
    @(posedge clk);
    #1;
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 100) begin
      num_errors++;
      report_and_stop();
    end
    got = rsp_data;
  endtask
  // A channel only records new signaling, and flags a change, while extraction is on.
  task automatic sig(input int ch, input logic [3:0] v);
    @(posedge clk);
    #1;
    sig_upd = 1'b1;
    sig_chan = 5'(ch);
    sig_abcd = v;
    if (ext_m[ch-1] && !freeze_m && v !== abcd_m[ch]) flags_m[ch-1] = 1'b1;
    if (ext_m[ch-1] && !freeze_m) abcd_m[ch] = v;
    @(posedge clk);
    #1;
    sig_upd = 1'b0;
  endtask
  task automatic chk_flags();
    for (int r = 0; r < 3; r++) begin
      run(drd, 8'hd6 + 8'(r), 8'h00);
      chk8("flags", flags_m[r*8 +: 8], got);
      chk8("flag lines", flags_m[r*8 +: 8], sig_change[r*8 +: 8]);
    end
  endtask
  function automatic logic [7:0] ind_byte(input int ch);
    return {3'b000, ext_m[ch-1], abcd_m[ch]};
  endfunction
  initial begin
    int n;
    logic [7:0] d;
    void'($urandom(62514));
    for (int i = 1; i <= 24; i++) abcd_m[i] = 4'h0;
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    foreach (rst_tab[i]) begin
      run(drd, rst_tab[i][15:8], 8'h00);
      chk8("reset value", rst_tab[i][7:0], got);
    end
    repeat (60) sig($urandom_range(24, 1), 4'($urandom));
    chk_flags();
    chk1("irq off", 1'b0, irq);
    run(dwr, 8'hd2, 8'h02);
    @(posedge clk);
    #1;
    chk1("irq on", |flags_m, irq);
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 3; r++) begin
        d = (p == 0) ? 8'($urandom) : 8'hff;
        run(dwr, 8'hd6 + 8'(r), d);
        flags_m[r*8 +: 8] = flags_m[r*8 +: 8] & ~d;
      end
      chk_flags();
    end
    chk1("irq cleared", 1'b0, irq);
    for (int c = 1; c <= 24; c++) begin
      run(ird, 8'(c), 8'h00);
      chk8("indirect read", ind_byte(c), got);
      chk1("address accepted", 1'b0, err);
    end
    for (int k = 0; k < 4; k++) begin
      n = (k == 1) ? 24 : ((k == 2) ? 12 : 1);
      d = {3'($urandom), 1'(k), 4'($urandom)};
      run(iwr, 8'(n), d);
      ext_m[n-1] = d[4];
      sig(n, ~abcd_m[n]);
      run(ird, 8'(n), 8'h00);
      chk8("indirect write", ind_byte(n), got);
    end
    chk_flags();
    foreach (rst_tab[i]) begin
      d = (i == 0) ? 8'h00 : ((i == 1) ? 8'h19 : 8'h7f);
      run(ird, d, 8'h00);
      chk1("address refused", 1'b1, err);
    end
    run(dwr, 8'hd4, 8'h85);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (busy === 1'b1) n++;
    end
    chk8("busy cycles", 8'h03, 8'(n));
    run(drd, 8'hd5, 8'h00);
    chk8("data after read", ind_byte(5), got);
    run(drd, 8'hd3, 8'h00);
    chk8("status idle", 8'h00, got);
    // With updates frozen a new code on an extracting channel is neither stored nor flagged.
    run(dwr, 8'hd2, 8'h0a);
    freeze_m = 1'b1;
    sig(7, ~abcd_m[7]);
    run(ird, 8'h07, 8'h00);
    chk8("frozen channel", ind_byte(7), got);
    chk_flags();
    report_and_stop();
  end
endmodule
`default_nettype wire
